// file: pkg/bac_pkg.sv
// Purpose: shared constants and types of the bypass attribute configuration block
// Assumes: one clock, 32-bit register port with protection sideband
// Notes: one config copy type serves both the secure and non-secure bank
package bac_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W_DEF = 16;
	// register offsets
	localparam logic [15:0] OFF_CFG0 = 16'h0000;
	localparam logic [15:0] OFF_NS_ALIAS = 16'h0400;
	// field positions
	localparam int POS_SEC_OVR = 28;
	localparam int POS_WA = 26;
	localparam int POS_RA = 24;
	localparam int POS_SH = 22;
	localparam int POS_SMCF = 21;
	localparam int POS_MT = 20;
	localparam int POS_ATTR_OVL = 16;
	localparam int POS_USF = 10;
	localparam int POS_CPD = 0;
	// override encodings
	localparam logic [1:0] OVR_PASS = 2'h0;
	localparam logic [1:0] OVR_SET = 2'h2;
	localparam logic [1:0] OVR_CLR = 2'h3;
	// reset values
	localparam logic [1:0] RST_OVR2 = 2'h0;
	localparam logic RST_MT = 1'b0;
	localparam logic [3:0] RST_ATTR_OVL = 4'h0;
	localparam logic RST_USF = 1'b0;
	localparam logic RST_CPD = 1'b1;
	localparam logic RST_SMCF = 1'b1;

	typedef struct packed {
		logic [1:0] sec_ovr;
		logic [1:0] wa;
		logic [1:0] ra;
		logic [1:0] sh;
		logic mt;
		logic [3:0] attr_ovl;
		logic usf;
		logic cpd;
	} bac_cfg_t;

	localparam bac_cfg_t CFG_RST = '{sec_ovr: RST_OVR2, wa: RST_OVR2, ra: RST_OVR2,
		sh: RST_OVR2, mt: RST_MT, attr_ovl: RST_ATTR_OVL, usf: RST_USF, cpd: RST_CPD};
endpackage

// file: pkg/bac_cfg_if.sv
// Purpose: carries both config banks from the register file to the attribute path
// Assumes: same clock on both ends
// Notes: plain levels, no handshake
`timescale 1ns/1ps
interface bac_cfg_if;
	import bac_pkg::*;
	bac_cfg_t s_cfg;
	bac_cfg_t ns_cfg;
	modport src (output s_cfg, output ns_cfg);
	modport dst (input s_cfg, input ns_cfg);
endinterface

// file: hw/bac_attr_path.sv
// Purpose: applies bypass overrides to client transaction attributes
// Assumes: transaction inputs come from logic on the same clock
// Notes: one cycle from input to registered output
`timescale 1ns/1ps
module bac_attr_path (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	bac_cfg_if.dst cfg, // both config banks
	input wire logic in_valid, // transaction present
	input wire logic in_write, // 1 write, 0 read
	input wire logic in_ns, // incoming non-secure sideband
	input wire logic in_alloc, // incoming allocation hint
	input wire logic [1:0] in_sh, // incoming shareability
	input wire logic [3:0] in_attr, // incoming memory attributes
	input wire logic in_sm_hit, // stream table matched
	input wire logic in_sm_multi, // several entries matched
	output logic out_valid, // result valid
	output logic out_ns, // resulting non-secure sideband
	output logic out_alloc, // resulting allocation hint
	output logic [1:0] out_sh, // resulting shareability
	output logic [3:0] out_attr, // resulting memory attributes
	output logic out_bypass, // transaction bypassed mapping
	output logic out_usf_fault, // unidentified stream fault
	output logic out_smc_fault // match conflict fault
);
	import bac_pkg::*;

	typedef struct packed {
		logic valid;
		logic ns;
		logic alloc;
		logic [1:0] sh;
		logic [3:0] attr;
		logic bypass;
		logic usf_fault;
		logic smc_fault;
	} bac_path_t;

	bac_path_t st_reg, st_next;
	bac_cfg_t sel;
	logic secure;
	logic bypass;
	logic [1:0] alloc_cfg;

	// override decision for one transaction
	always_comb begin
		secure = ~in_ns;
		sel = secure ? cfg.s_cfg : cfg.ns_cfg; // bank follows transaction security
		bypass = sel.cpd | (~in_sm_hit & ~sel.usf);
		alloc_cfg = in_write ? sel.wa : sel.ra;
		st_next = '0;
		st_next.valid = in_valid;
		st_next.bypass = in_valid & bypass;
		st_next.usf_fault = in_valid & ~sel.cpd & ~in_sm_hit & sel.usf;
		// conflict fault always enabled; detection limited to flagged matches
		st_next.smc_fault = in_valid & ~sel.cpd & in_sm_hit & in_sm_multi;
		st_next.ns = in_ns;
		if (secure && bypass) begin
			unique case (sel.sec_ovr)
				OVR_SET: st_next.ns = 1'b0;
				OVR_CLR: st_next.ns = 1'b1;
				default: st_next.ns = in_ns;
			endcase
		end
		st_next.alloc = in_alloc;
		if (bypass) begin
			unique case (alloc_cfg)
				OVR_SET: st_next.alloc = 1'b1;
				OVR_CLR: st_next.alloc = 1'b0;
				default: st_next.alloc = in_alloc;
			endcase
		end
		st_next.sh = (bypass && sel.sh != OVR_PASS) ? sel.sh : in_sh;
		st_next.attr = (!secure && bypass && sel.mt) ? sel.attr_ovl : in_attr;
	end

	// output registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign out_valid = st_reg.valid;
	assign out_ns = st_reg.ns;
	assign out_alloc = st_reg.alloc;
	assign out_sh = st_reg.sh;
	assign out_attr = st_reg.attr;
	assign out_bypass = st_reg.bypass;
	assign out_usf_fault = st_reg.usf_fault;
	assign out_smc_fault = st_reg.smc_fault;
endmodule

// file: hw/bac_top.sv
// Purpose: banked top-level configuration register and bypass attribute overrides
// Assumes: register port with protection sideband, single clock
// Notes: secure bank at offset 0 for secure accesses, alias for the non-secure bank
// Summary of operation
// - secure config bank reachable by secure accesses only
// - security override: pass, force secure, force non-secure
// - security override absent in non-secure bank
// - security override only for bypassing secure transactions
// - write allocate hint override for bypass writes
// - read allocate hint override for bypass reads
// - allocation overrides only for bypassing transactions
// - two-bit shareability field for bypass transactions
// - match conflict setting reads one, writes ignored
// - not every match conflict is detected
// - memory type override bit, resets to zero
// - memory type override only non-secure bypass
// - attribute field replaces memory attributes when enabled
// - client port disable resets set, means bypass
// - unmatched stream passes or faults per setting
`timescale 1ns/1ps
module bac_top #(
	parameter int ADDR_W = bac_pkg::ADDR_W_DEF
) (
	input wire logic CORE_CLK, // core clock
	input wire logic NRST, // async reset, active low
	input wire logic PSEL, // register port select
	input wire logic PENABLE, // access phase
	input wire logic PWRITE, // 1 write, 0 read
	input wire logic [ADDR_W-1:0] PADDR, // byte address
	input wire logic [bac_pkg::DATA_W-1:0] PWDATA, // write data
	input wire logic [2:0] PPROT, // protection sideband
	output logic [bac_pkg::DATA_W-1:0] PRDATA, // read data
	output logic PREADY, // transfer done
	output logic PSLVERR, // never asserted
	input wire logic TXN_VALID, // client transaction present
	input wire logic TXN_WRITE, // 1 write, 0 read
	input wire logic TXN_NS, // incoming non-secure sideband
	input wire logic TXN_ALLOC, // incoming allocation hint
	input wire logic [1:0] TXN_SH, // incoming shareability
	input wire logic [3:0] TXN_ATTR, // incoming memory attributes
	input wire logic TXN_SM_HIT, // stream table matched
	input wire logic TXN_SM_MULTI, // several entries matched
	output logic OUT_VALID, // result valid
	output logic OUT_NS, // resulting non-secure sideband
	output logic OUT_ALLOC, // resulting allocation hint
	output logic [1:0] OUT_SH, // resulting shareability
	output logic [3:0] OUT_ATTR, // resulting memory attributes
	output logic OUT_BYPASS, // bypassed mapping
	output logic OUT_USF_FAULT, // unidentified stream fault
	output logic OUT_SMC_FAULT // match conflict fault
);
	import bac_pkg::*;

	// refuse an address too narrow for the alias offset
	if (ADDR_W < 11 || ADDR_W > 16) begin : g_chk
		$error("bac_top: ADDR_W must be 11 to 16");
	end

	typedef struct packed {
		bac_cfg_t s_cfg;
		bac_cfg_t ns_cfg;
		logic [DATA_W-1:0] rdata;
		logic ready;
		logic slverr;
	} bac_top_t;

	bac_top_t st_reg, st_next;
	logic access_ok;
	logic acc_secure;
	logic hit_cfg0;
	logic hit_alias;
	logic setup;
	logic do_write;

	// pack one bank into the register word
	function automatic logic [DATA_W-1:0] cfg_to_word(bac_cfg_t c, logic secure_bank);
		logic [DATA_W-1:0] w;
		w = '0; // reserved and unimplemented bits read zero
		if (secure_bank) begin
			w[POS_SEC_OVR +: 2] = c.sec_ovr;
		end
		w[POS_WA +: 2] = c.wa;
		w[POS_RA +: 2] = c.ra;
		w[POS_SH +: 2] = c.sh;
		w[POS_SMCF] = RST_SMCF;
		w[POS_MT] = c.mt;
		w[POS_ATTR_OVL +: 4] = c.attr_ovl;
		w[POS_USF] = c.usf;
		w[POS_CPD] = c.cpd;
		return w;
	endfunction

	// unpack a written word into a bank
	function automatic bac_cfg_t word_to_cfg(logic [DATA_W-1:0] w, logic secure_bank);
		bac_cfg_t c;
		c.sec_ovr = secure_bank ? w[POS_SEC_OVR +: 2] : RST_OVR2;
		c.wa = w[POS_WA +: 2];
		c.ra = w[POS_RA +: 2];
		c.sh = w[POS_SH +: 2];
		c.mt = w[POS_MT];
		c.attr_ovl = w[POS_ATTR_OVL +: 4];
		c.usf = w[POS_USF];
		c.cpd = w[POS_CPD];
		return c;
	endfunction

	// access qualification and decode
	always_comb begin
		access_ok = PPROT[0] & ~PPROT[2]; // privileged data only
		acc_secure = ~PPROT[1];
		hit_cfg0 = (PADDR == OFF_CFG0[ADDR_W-1:0]);
		hit_alias = (PADDR == OFF_NS_ALIAS[ADDR_W-1:0]) & acc_secure;
		setup = PSEL & ~PENABLE;
		do_write = PSEL & PENABLE & PWRITE & st_reg.ready & access_ok;
	end

	// register file next state
	always_comb begin
		st_next = st_reg;
		st_next.ready = setup;
		st_next.slverr = 1'b0; // refused accesses end without error
		if (setup) begin
			st_next.rdata = '0;
			if (access_ok && !PWRITE) begin
				if (hit_cfg0) begin
					// access security picks the bank
					st_next.rdata = acc_secure ? cfg_to_word(st_reg.s_cfg, 1'b1)
						: cfg_to_word(st_reg.ns_cfg, 1'b0);
				end else if (hit_alias) begin
					st_next.rdata = cfg_to_word(st_reg.ns_cfg, 1'b0);
				end
			end
		end
		if (do_write) begin
			if (hit_cfg0 && acc_secure) begin
				st_next.s_cfg = word_to_cfg(PWDATA, 1'b1);
			end else if (hit_cfg0 || hit_alias) begin
				st_next.ns_cfg = word_to_cfg(PWDATA, 1'b0);
			end
		end
	end

	// state registers
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			st_reg.s_cfg <= CFG_RST;
			st_reg.ns_cfg <= CFG_RST;
			st_reg.rdata <= '0;
			st_reg.ready <= 1'b0;
			st_reg.slverr <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// register port outputs
	assign PRDATA = st_reg.rdata;
	assign PREADY = st_reg.ready;
	assign PSLVERR = st_reg.slverr;

	// config banks to the attribute path
	bac_cfg_if cfg_if ();
	assign cfg_if.s_cfg = st_reg.s_cfg;
	assign cfg_if.ns_cfg = st_reg.ns_cfg;

	bac_attr_path u_path (
		.clk(CORE_CLK),
		.rst_n(NRST),
		.cfg(cfg_if.dst),
		.in_valid(TXN_VALID),
		.in_write(TXN_WRITE),
		.in_ns(TXN_NS),
		.in_alloc(TXN_ALLOC),
		.in_sh(TXN_SH),
		.in_attr(TXN_ATTR),
		.in_sm_hit(TXN_SM_HIT),
		.in_sm_multi(TXN_SM_MULTI),
		.out_valid(OUT_VALID),
		.out_ns(OUT_NS),
		.out_alloc(OUT_ALLOC),
		.out_sh(OUT_SH),
		.out_attr(OUT_ATTR),
		.out_bypass(OUT_BYPASS),
		.out_usf_fault(OUT_USF_FAULT),
		.out_smc_fault(OUT_SMC_FAULT)
	);
endmodule

// file: testbench/bac_top_assertions.sv
// Purpose: port-level checks of the bypass attribute configuration block
// Assumes: single clock, async active-low reset
// Notes: bound into every bac_top instance
`timescale 1ns/1ps
module bac_top_assertions #(
	parameter int ADDR_W = 16
) (
	input wire logic CORE_CLK, // clock
	input wire logic NRST, // reset
	input wire logic PSEL, // select
	input wire logic PENABLE, // access phase
	input wire logic PWRITE, // direction
	input wire logic [ADDR_W-1:0] PADDR, // address
	input wire logic [2:0] PPROT, // protection
	input wire logic [bac_pkg::DATA_W-1:0] PRDATA, // read data
	input wire logic PREADY, // done
	input wire logic TXN_VALID, // in present
	input wire logic TXN_NS, // in sideband
	input wire logic TXN_ALLOC, // in hint
	input wire logic [3:0] TXN_ATTR, // in attrs
	input wire logic TXN_SM_HIT, // matched
	input wire logic TXN_SM_MULTI, // multi match
	input wire logic OUT_VALID, // out present
	input wire logic OUT_NS, // out sideband
	input wire logic OUT_ALLOC, // out hint
	input wire logic [3:0] OUT_ATTR, // out attrs
	input wire logic OUT_BYPASS, // bypassed
	input wire logic OUT_USF_FAULT, // unmatched fault
	input wire logic OUT_SMC_FAULT // conflict fault
);
	import bac_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// register port phases
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_good_rd;
		PREADY && !PWRITE && PPROT[0] && !PPROT[2] && PADDR == '0;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> PREADY ##1 !PREADY)
		else $error("ready pulse wrong");
	a_conflict_reads_one: assert property (s_good_rd |-> PRDATA[21] && PRDATA[31:30] == 2'b00)
		else $error("fixed bits wrong");
	a_unpriv_reads_zero: assert property (PREADY && !PPROT[0] |-> PRDATA == '0)
		else $error("unprivileged read not zero");
	a_conflict_fault_cause: assert property (OUT_SMC_FAULT |-> $past(TXN_SM_HIT && TXN_SM_MULTI) && !OUT_BYPASS)
		else $error("conflict fault without cause");
	a_unmatched_one_path: assert property (TXN_VALID && !TXN_SM_HIT |=> OUT_BYPASS != OUT_USF_FAULT)
		else $error("unmatched neither bypass nor fault");
	a_mapped_attr_pass: assert property (OUT_VALID && !OUT_BYPASS |-> OUT_NS == $past(TXN_NS)
		&& OUT_ALLOC == $past(TXN_ALLOC) && OUT_ATTR == $past(TXN_ATTR))
		else $error("attributes changed without bypass");
	a_ns_stays_ns: assert property (TXN_NS |=> OUT_NS)
		else $error("non-secure made secure");
	a_secure_attr_kept: assert property (!TXN_NS |=> OUT_ATTR == $past(TXN_ATTR))
		else $error("secure memory attributes changed");
endmodule
bind bac_top bac_top_assertions #(.ADDR_W(ADDR_W)) i_bac_top_assertions (.*);

// file: testbench/bac_client_model.sv
// Purpose: client master issuing one transaction per send call
// Assumes: driven just after the rising edge
// Notes: memory attributes invert after each transfer, other sidebands hold
`timescale 1ns/1ps
module bac_client_model (
	input wire logic clk, // clock
	output logic TXN_VALID = 1'b0, // present
	output logic TXN_WRITE = 1'b0, // direction
	output logic TXN_NS = 1'b0, // sideband
	output logic TXN_ALLOC = 1'b0, // hint
	output logic [1:0] TXN_SH = 2'h0, // shareability
	output logic [3:0] TXN_ATTR = 4'h0, // attrs
	output logic TXN_SM_HIT = 1'b0, // matched
	output logic TXN_SM_MULTI = 1'b0 // multi match
);
	// one-cycle transfer, then stale attributes inverted
	task automatic send(input logic w, ns, al, input logic [1:0] sh,
		input logic [3:0] ma, input logic hit, mu);
		@(posedge clk);
		#1;
		{TXN_VALID, TXN_WRITE, TXN_NS, TXN_ALLOC} = {1'b1, w, ns, al};
		{TXN_SH, TXN_ATTR, TXN_SM_HIT, TXN_SM_MULTI} = {sh, ma, hit, mu};
		@(posedge clk);
		#1;
		TXN_VALID = 1'b0;
		TXN_ATTR = ~TXN_ATTR;
	endtask
endmodule

// file: testbench/tb_top.sv
// Purpose: register and transaction tests of the bypass block
// Assumes: wait-free register port, one-cycle attribute path
// Notes: expectations built from field codings
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
	checked++; \
	if ((a) !== (e)) begin \
		miscompares++; \
		$display("ERROR %s exp %h got %h", n, e, a); \
	end \
end
module tb_top;
	import bac_pkg::*;
	localparam logic [2:0] SEC = 3'h1, NSEC = 3'h3, UPR = 3'h0, INS = 3'h5;
	logic CORE_CLK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [15:0] PADDR = 16'h0000;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
	logic [2:0] PPROT = 3'h0;
	logic PREADY, PSLVERR, TXN_VALID, TXN_WRITE, TXN_NS, TXN_ALLOC, TXN_SM_HIT, TXN_SM_MULTI;
	logic [1:0] TXN_SH, OUT_SH;
	logic [3:0] TXN_ATTR, OUT_ATTR;
	logic OUT_VALID, OUT_NS, OUT_ALLOC, OUT_BYPASS, OUT_USF_FAULT, OUT_SMC_FAULT;
	int checked = 0, miscompares = 0;
	bac_top i_bac_top (.*);
	bac_client_model i_bac_client_model (.clk(CORE_CLK), .*);
	// 100 MHz clock
	always #5 CORE_CLK = ~CORE_CLK;
	// verdict and end of run
	task automatic test_done;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one register transfer, bounded wait for ready
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [2:0] p, output logic [31:0] r);
		int i;
		@(posedge CORE_CLK);
		#1;
		{PSEL, PWRITE, PADDR, PWDATA, PPROT} = {1'b1, w, a, d, p};
		@(posedge CORE_CLK);
		#1;
		PENABLE = 1'b1;
		i = 0;
		do begin
			@(posedge CORE_CLK);
			i++;
		end while (PREADY !== 1'b1 && i < 8);
		r = PRDATA;
		if (PREADY !== 1'b1) begin
			miscompares++;
			test_done();
		end
		#1;
		{PSEL, PENABLE} = 2'b00;
	endtask
	task automatic wr(input logic [15:0] a, input logic [2:0] p, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, p, r);
	endtask
	task automatic rd(input logic [15:0] a, input logic [2:0] p, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, p, r);
		`CHK("rdata", e, r)
	endtask
	// valid, bypass, faults, sideband, hint, shareability, attrs
	task automatic expo(input logic [11:0] e);
		`CHK("attrs", e, {OUT_VALID, OUT_BYPASS, OUT_USF_FAULT, OUT_SMC_FAULT,
			OUT_NS, OUT_ALLOC, OUT_SH, OUT_ATTR})
	endtask
	// main sequence
	initial begin
		logic [1:0] f;
		repeat (16) @(posedge CORE_CLK);
		#1;
		NRST = 1'b1;
		rd(16'h0000, SEC, 32'h0020_0001);
		rd(16'h0000, NSEC, 32'h0020_0001);
		wr(16'h0000, SEC, 32'hFFFF_FFFF);
		rd(16'h0000, SEC, 32'h3FFF_0401);
		wr(16'h0000, NSEC, 32'hFFFF_FFFF);
		rd(16'h0400, SEC, 32'h0FFF_0401);
		rd(16'h0400, NSEC, 32'h0000_0000);
		rd(16'h0000, UPR, 32'h0000_0000);
		rd(16'h0000, INS, 32'h0000_0000);
		`CHK("pslverr", 1'b0, PSLVERR)
		wr(16'h0000, UPR, 32'h0000_0000);
		rd(16'h0000, SEC, 32'h3FFF_0401);
		rd(16'h0008, SEC, 32'h0000_0000);
		// every override code on writes and reads of both hints
		for (int c = 0; c < 4; c++) begin
			wr(16'h0000, SEC, {2'b00, c[1:0], c[1:0], c[1:0] ^ 2'b01, 24'h00_0000});
			for (int j = 0; j < 4; j++) begin
				f = j[0] ? c[1:0] : c[1:0] ^ 2'b01;
				i_bac_client_model.send(j[0], 1'b0, j[1], 2'b00, 4'h5, 1'b0, 1'b0);
				expo({4'b1100, c[1:0] == OVR_CLR, f == OVR_SET || (f != OVR_CLR && j[1]),
					6'h05});
			end
		end
		i_bac_client_model.send(1'b1, 1'b0, 1'b1, 2'b11, 4'h5, 1'b1, 1'b0);
		expo({4'b1000, 1'b0, 1'b1, 2'b11, 4'h5});
		wr(16'h0000, SEC, 32'h0000_0400);
		i_bac_client_model.send(1'b0, 1'b0, 1'b0, 2'b00, 4'h5, 1'b0, 1'b0);
		expo({4'b1010, 8'h05});
		i_bac_client_model.send(1'b0, 1'b0, 1'b0, 2'b00, 4'h5, 1'b1, 1'b1);
		expo({4'b1001, 8'h05});
		// memory type overlay and shareability in the non-secure bank, then overlay ignored for secure bank
		wr(16'h0400, SEC, 32'h009A_0001);
		i_bac_client_model.send(1'b0, 1'b1, 1'b1, 2'b01, 4'h5, 1'b0, 1'b0);
		expo({4'b1100, 1'b1, 1'b1, 2'b10, 4'hA});
		wr(16'h0400, SEC, 32'h000A_0001);
		i_bac_client_model.send(1'b0, 1'b1, 1'b1, 2'b01, 4'h5, 1'b0, 1'b0);
		expo({4'b1100, 1'b1, 1'b1, 2'b01, 4'h5});
		wr(16'h0000, SEC, 32'h001A_0001);
		i_bac_client_model.send(1'b0, 1'b0, 1'b1, 2'b01, 4'h5, 1'b0, 1'b0);
		expo({4'b1100, 1'b0, 1'b1, 2'b01, 4'h5});
		test_done();
	end
endmodule
